// >>> core/cosd_pkg.sv
package cosd_pkg;
   localparam int NCH = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   // register byte addresses on the plain port (byte address = 4 * index)
   localparam logic [7:0] REG_SEL0 = 8'h00;
   localparam logic [7:0] REG_SEL1 = 8'h04;
   localparam logic [7:0] REG_FIFO = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_CTRL = 8'h10;
   localparam logic [7:0] REG_ISTS = 8'h14;
   localparam logic [7:0] REG_IMSK = 8'h18;
   localparam logic [7:0] REG_DATA = 8'h1C;
   // status register fields
   localparam int STAT_EMPTY = 0;
   localparam int STAT_FULL = 1;
   localparam int STAT_CNT_LSB = 8;
   // control register fields
   localparam int CTRL_RWE = 0;
   localparam int CTRL_SEQ = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   // interrupt status/mask fields
   localparam int IRQ_EVT = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_NE = 2;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // timing
   localparam real BUS_MHZ = 250.0;
   localparam real SYNC_MHZ = 16.0;
   localparam int SYNC_DIV = int'(BUS_MHZ / SYNC_MHZ);
   localparam real DEB_NS = 1000.0;
   localparam int DEB_CYC = int'(DEB_NS * BUS_MHZ / 1000.0);
   localparam logic [9:0] DEB_CNT = 10'(DEB_CYC);
   localparam logic [4:0] SYNC_CNT = 5'(SYNC_DIV - 1);
   typedef enum logic [1:0] {
      COSD_DATA_ONLY = 2'h0,
      COSD_RISE = 2'h1,
      COSD_FALL = 2'h2,
      COSD_ANY = 2'h3
   } cosd_sel_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cosd_req_t;
   typedef enum logic [1:0] {
      COSD_PRIME = 2'h0,
      COSD_IDLE = 2'h1,
      COSD_WRITE = 2'h3
   } cosd_st_t;
endpackage

// >>> core/cosd_fifo.sv
`timescale 1ns/1ps
module cosd_fifo (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // write side
   input wire logic wr_valid,
   input wire logic [31:0] wr_data,
   output logic wr_ready,
   // read side
   input wire logic rd_ready,
   output logic rd_valid,
   output logic [31:0] rd_data,
   output logic [cosd_pkg::FIFO_AW:0] count
);
   logic [31:0] mem [cosd_pkg::FIFO_DEPTH];
   logic [cosd_pkg::FIFO_AW-1:0] wp_r;
   logic [cosd_pkg::FIFO_AW-1:0] rp_r;
   logic [cosd_pkg::FIFO_AW:0] cnt_r;
   logic do_wr;
   logic do_rd;

   assign wr_ready = (cnt_r != (cosd_pkg::FIFO_AW+1)'(cosd_pkg::FIFO_DEPTH));
   assign rd_valid = (cnt_r != '0);
   assign do_wr = wr_valid && wr_ready;
   assign do_rd = rd_ready && rd_valid;
   assign rd_data = mem[rp_r];
   assign count = cnt_r;

   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wp_r] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_wr) begin
            wp_r <= wp_r + 1'b1;
         end
         if (do_rd) begin
            rp_r <= rp_r + 1'b1;
         end
         case ({do_wr, do_rd})
            2'b10: cnt_r <= cnt_r + 1'b1;
            2'b01: cnt_r <= cnt_r - 1'b1;
            default: cnt_r <= cnt_r;
         endcase
      end
   end
endmodule

// >>> core/cosd_top.sv
`timescale 1ns/1ps
module cosd_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // field inputs
   input wire logic [31:0] din,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // interrupt processor
   output logic irq_req,
   output logic irq
);
   cosd_pkg::cosd_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // 16 MHz sampling enable derived from the bus clock
   logic [4:0] sdiv_r;
   logic stick;
   assign stick = (sdiv_r == cosd_pkg::SYNC_CNT);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sdiv_r <= '0;
      end else if (stick) begin
         sdiv_r <= '0;
      end else begin
         sdiv_r <= sdiv_r + 5'h01;
      end
   end

   // two-stage synchroniser clocked at the 16 MHz rate
   logic [31:0] sync1_r;
   logic [31:0] sync2_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (stick) begin
         sync1_r <= din;
         sync2_r <= sync1_r;
      end
   end

   // debounce: timer starts on any difference between synced and debounced data
   logic [31:0] deb_r;
   logic [9:0] dcnt_r;
   logic drun_r;
   logic debounce_tick;
   logic primed_r;
   assign debounce_tick = drun_r && (dcnt_r == '0);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dcnt_r <= '0;
         drun_r <= 1'b0;
      end else if (!drun_r) begin
         if ((sync2_r != deb_r) || !primed_r) begin
            drun_r <= 1'b1;
            dcnt_r <= cosd_pkg::DEB_CNT;
         end
      end else if (dcnt_r == '0) begin
         drun_r <= 1'b0;
      end else begin
         dcnt_r <= dcnt_r - 10'h001;
      end
   end

   // a level that bounces back before the tick is filtered out
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         deb_r <= '0;
      end else if (debounce_tick) begin
         deb_r <= sync2_r;
      end
   end

   // registers
   logic [31:0] sel0_r;
   logic [31:0] sel1_r;
   logic [1:0] ctrl_r;
   logic [2:0] ists_r;
   logic [2:0] imsk_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel0_r <= '0;
         sel1_r <= '0;
         ctrl_r <= cosd_pkg::CTRL_RST;
         imsk_r <= cosd_pkg::IRQ_RST;
      end else if (req.wr) begin
         case (req.addr)
            cosd_pkg::REG_SEL0: sel0_r <= req.wdata;
            cosd_pkg::REG_SEL1: sel1_r <= req.wdata;
            cosd_pkg::REG_CTRL: ctrl_r <= req.wdata[1:0];
            cosd_pkg::REG_IMSK: imsk_r <= req.wdata[2:0];
            default: ;
         endcase
      end
   end

   // per channel selects: channels 0..15 in sel0, 16..31 in sel1, two bits each
   logic [1:0] chan_sel [cosd_pkg::NCH];
   logic [31:0] rise;
   logic [31:0] fall;
   logic [31:0] flag_bits;
   logic [31:0] prev_r;
   logic [31:0] snap_r;
   genvar g;
   generate
      for (g = 0; g < cosd_pkg::NCH; g++) begin : g_ch
         if (g < 16) begin : g_lo
            assign chan_sel[g] = sel0_r[2*g +: 2];
         end else begin : g_hi
            assign chan_sel[g] = sel1_r[2*(g-16) +: 2];
         end
         assign rise[g] = snap_r[g] && !prev_r[g];
         assign fall[g] = !snap_r[g] && prev_r[g];
         always_comb begin
            case (cosd_pkg::cosd_sel_t'(chan_sel[g]))
               cosd_pkg::COSD_DATA_ONLY: flag_bits[g] = 1'b0;
               cosd_pkg::COSD_RISE: flag_bits[g] = rise[g];
               cosd_pkg::COSD_FALL: flag_bits[g] = fall[g];
               cosd_pkg::COSD_ANY: flag_bits[g] = rise[g] | fall[g];
               default: flag_bits[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   // detector on the bus clock: snapshot on tick, compare, then write and update old state on the same edge
   cosd_pkg::cosd_st_t st_r;
   logic chk_r;
   logic flagged;
   logic fifo_wv;
   logic fifo_wready;
   logic fifo_rv;
   logic [31:0] fifo_rdata;
   logic [cosd_pkg::FIFO_AW:0] fifo_cnt;
   logic fifo_pop;
   logic ovf_ev;
   assign flagged = chk_r && (flag_bits != '0);
   assign fifo_wv = (st_r == cosd_pkg::COSD_WRITE);
   assign ovf_ev = fifo_wv && !fifo_wready;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         snap_r <= '0;
         chk_r <= 1'b0;
      end else begin
         chk_r <= debounce_tick && primed_r;
         if (debounce_tick) begin
            snap_r <= sync2_r;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= cosd_pkg::COSD_PRIME;
         prev_r <= '0;
         primed_r <= 1'b0;
      end else begin
         case (st_r)
            cosd_pkg::COSD_PRIME: begin
               if (debounce_tick) begin
                  prev_r <= sync2_r;
                  primed_r <= 1'b1;
                  st_r <= cosd_pkg::COSD_IDLE;
               end
            end
            cosd_pkg::COSD_IDLE: begin
               if (flagged) begin
                  st_r <= cosd_pkg::COSD_WRITE;
               end else if (chk_r) begin
                  prev_r <= snap_r;
               end
            end
            cosd_pkg::COSD_WRITE: begin
               // entry goes in this cycle, old state is updated on the same edge
               prev_r <= snap_r;
               st_r <= cosd_pkg::COSD_IDLE;
            end
            default: st_r <= cosd_pkg::COSD_IDLE;
         endcase
      end
   end

   // a full fifo drops the entry; overflow is flagged so software can see the loss
   cosd_fifo u_fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wr_valid(fifo_wv),
      .wr_data(snap_r),
      .wr_ready(fifo_wready),
      .rd_ready(fifo_pop),
      .rd_valid(fifo_rv),
      .rd_data(fifo_rdata),
      .count(fifo_cnt)
   );
   assign fifo_pop = req.rd && (req.addr == cosd_pkg::REG_FIFO);

   // request toward the interrupt processor
   logic pend_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_r <= 1'b0;
      end else if (fifo_wv && fifo_wready) begin
         pend_r <= 1'b1;
      end else if (!ctrl_r[cosd_pkg::CTRL_RWE] && fifo_pop) begin
         pend_r <= 1'b0; // release on first read, re-armed if entries remain
      end else if (!fifo_rv) begin
         pend_r <= 1'b0;
      end else if (!ctrl_r[cosd_pkg::CTRL_RWE]) begin
         pend_r <= 1'b1;
      end
   end
   // release-when-empty keeps request high while anything is stored
   assign irq_req = ctrl_r[cosd_pkg::CTRL_RWE] ? fifo_rv : pend_r;

   // sticky status; set wins over a write-one-to-clear in the same cycle
   logic [2:0] iset;
   assign iset = {fifo_rv, ovf_ev, fifo_wv && fifo_wready};
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ists_r <= cosd_pkg::IRQ_RST;
      end else begin
         ists_r <= (ists_r & ~((req.wr && req.addr == cosd_pkg::REG_ISTS) ? req.wdata[2:0] : 3'h0)) | iset;
      end
   end
   assign irq = |(ists_r & imsk_r);

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (req.rd) begin
         case (req.addr)
            cosd_pkg::REG_SEL0: reg_rdata <= sel0_r;
            cosd_pkg::REG_SEL1: reg_rdata <= sel1_r;
            cosd_pkg::REG_FIFO: reg_rdata <= fifo_rv ? fifo_rdata : 32'h0000_0000;
            cosd_pkg::REG_STAT: reg_rdata <= {19'h0, fifo_cnt, 6'h00, !fifo_wready, !fifo_rv};
            cosd_pkg::REG_CTRL: reg_rdata <= {30'h0, ctrl_r};
            cosd_pkg::REG_ISTS: reg_rdata <= {29'h0, ists_r};
            cosd_pkg::REG_IMSK: reg_rdata <= {29'h0, imsk_r};
            cosd_pkg::REG_DATA: reg_rdata <= deb_r;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule

// >>> testbench/cosd_top_asserts.sv
`timescale 1ns/1ps
module cosd_top_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // watched ports
   input wire logic [31:0] din,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic irq_req,
   input wire logic irq
);
   logic [31:0] din_q_r;
   logic [9:0] quiet_r;
   logic [2:0] acc_r;
   logic moved_r;
   logic rwe_r;
   logic [63:0] sel_r;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   always_ff @(posedge ref_clk) begin
      din_q_r <= din;
   end
   // cycles since the inputs last moved, held at the top
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_r <= 10'h000;
      end else if (din != din_q_r) begin
         quiet_r <= 10'h000;
      end else if (quiet_r != 10'h3FF) begin
         quiet_r <= quiet_r + 10'h001;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         moved_r <= 1'b0;
      end else if (din != din_q_r) begin
         moved_r <= 1'b1;
      end
   end
   // a register access may legally bounce the request, so rises near one are excused
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= 3'h7;
      end else if (reg_rd || reg_wr) begin
         acc_r <= 3'h0;
      end else if (acc_r != 3'h7) begin
         acc_r <= acc_r + 3'h1;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rwe_r <= cosd_pkg::CTRL_RST[cosd_pkg::CTRL_RWE];
         sel_r <= 64'h0;
      end else if (reg_wr) begin
         if (reg_addr == cosd_pkg::REG_CTRL) rwe_r <= reg_wdata[cosd_pkg::CTRL_RWE];
         if (reg_addr == cosd_pkg::REG_SEL0) sel_r[31:0] <= reg_wdata;
         if (reg_addr == cosd_pkg::REG_SEL1) sel_r[63:32] <= reg_wdata;
      end
   end
   a_irq_hold: assert property (irq_req && !(reg_rd && reg_addr == cosd_pkg::REG_FIFO) |=> irq_req)
      else $error("request dropped without a fifo read");
   a_entry_cause: assert property ($rose(irq_req) && acc_r > 3'h3 |-> quiet_r < 10'h190)
      else $error("request rose with quiet inputs");
   a_prime_quiet: assert property (!moved_r |-> !irq_req)
      else $error("entry before any input change");
   a_sel_read: assert property (reg_rd && (reg_addr == cosd_pkg::REG_SEL0 || reg_addr == cosd_pkg::REG_SEL1) |=>
      reg_rdata == 32'(sel_r >> {$past(reg_addr[2]), 5'h00}))
      else $error("select readback wrong");
   a_data_read: assert property (reg_rd && reg_addr == cosd_pkg::REG_DATA && quiet_r > 10'h18F |=>
      reg_rdata == $past(din))
      else $error("settled input data wrong");
   a_empty_flag: assert property (reg_rd && reg_addr == cosd_pkg::REG_STAT && rwe_r |=>
      reg_rdata[cosd_pkg::STAT_EMPTY] == !$past(irq_req))
      else $error("empty flag disagrees with request");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   a_unmapped_rd: assert property (reg_rd && reg_addr > cosd_pkg::REG_DATA |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind cosd_top cosd_top_asserts u_cosd_top_asserts (.ref_clk(ref_clk), .arst_n(arst_n), .din(din),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq_req(irq_req), .irq(irq));

// >>> testbench/cosd_field.sv
`timescale 1ns/1ps
module cosd_field (
   // clock
   input wire logic ref_clk,
   // wanted levels and pins
   input wire logic [31:0] want,
   output logic [31:0] din
);
   logic [31:0] late_r = 32'h0;
   // upper half lags a cycle, like unmatched cable runs
   always @(posedge ref_clk) begin
      late_r <= want;
   end
   assign din = {late_r[31:16], want[15:0]};
endmodule

// >>> testbench/change_of_state_detector_test.sv
`timescale 1ns/1ps
module change_of_state_detector_test;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] want = 32'hA5A5_0F0F;
   logic [31:0] din;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq_req;
   logic irq;
   logic irq_a;
   logic seen_req = 1'b0;
   int miscompares = 0;
   int checks_done = 0;
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   cosd_field u_cosd_field (.ref_clk(ref_clk), .want(want), .din(din));
   cosd_top u_cosd_top (.ref_clk(ref_clk), .arst_n(arst_n), .din(din), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_req(irq_req), .irq(irq));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      seen_req = irq_req;
      chk(what, reg_rdata, exp);
      @(posedge ref_clk);
   endtask
   // 600 cycles covers sampling, debounce and the fifo write
   task automatic put(input logic [31:0] val);
      want <= val;
      repeat (600) @(posedge ref_clk);
      @(negedge ref_clk);
      seen_req = irq_req;
      @(posedge ref_clk);
   endtask
   task automatic expect_entry(input logic [31:0] val, input logic hit);
      chk("request", 32'(seen_req), 32'(hit));
      rd(cosd_pkg::REG_FIFO, "entry", hit ? val : 32'h0);
      chk("request after pop", 32'(seen_req), 32'h0);
   endtask
   task automatic t_start();
      put(32'hA5A5_0F0F);
      chk("request", 32'(seen_req), 32'h0);
      rd(cosd_pkg::REG_DATA, "inputs", 32'hA5A5_0F0F);
      rd(cosd_pkg::REG_STAT, "status", 32'h1);
      rd(cosd_pkg::REG_CTRL, "control", 32'(cosd_pkg::CTRL_RST));
      rd(cosd_pkg::REG_ISTS, "events", 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, "unmapped", 32'h0);
      put(32'h1);
      chk("request", 32'(seen_req), 32'h0);
   endtask
   task automatic t_modes();
      int ch;
      logic [7:0] a;
      for (int s = 0; s < 4; s++) begin
         ch = s * 9 + 2;
         a = ch < 16 ? cosd_pkg::REG_SEL0 : cosd_pkg::REG_SEL1;
         wr(a, 32'(s) << (2 * (ch % 16)));
         rd(a, "select", 32'(s) << (2 * (ch % 16)));
         put(32'h1 | (32'h1 << ch));
         expect_entry(32'h1 | (32'h1 << ch), 1'(s));
         put(32'h1);
         expect_entry(32'h1, 1'(s >> 1));
         wr(a, 32'h0);
      end
   endtask
   task automatic t_walk();
      logic [31:0] q[$];
      wr(cosd_pkg::REG_SEL0, 32'hFFFF_FFFF);
      wr(cosd_pkg::REG_SEL1, 32'hFFFF_FFFF);
      for (int i = 0; i < 8; i++) begin
         put(32'h0);
         put(32'h2 << i);
         chk("request", 32'(seen_req), 32'h1);
         q.push_back(32'h0);
         q.push_back(32'h2 << i);
      end
      put(32'h0);
      rd(cosd_pkg::REG_STAT, "status", 32'h1002);
      rd(cosd_pkg::REG_ISTS, "events", 32'h7);
      wr(cosd_pkg::REG_IMSK, 32'h7);
      irq_a = irq;
      wr(cosd_pkg::REG_IMSK, 32'h0);
      chk("mask effect", 32'(irq_a ^ irq), 32'h1);
      foreach (q[k]) rd(cosd_pkg::REG_FIFO, "entry", q[k]);
      chk("request", 32'(seen_req), 32'h0);
      wr(cosd_pkg::REG_ISTS, 32'h7);
      rd(cosd_pkg::REG_ISTS, "events", 32'h0);
      chk("interrupt", 32'(irq), 32'h0);
   endtask
   // release-when-empty off: request drops for the pop, then comes back while entries remain
   task automatic t_release();
      wr(cosd_pkg::REG_CTRL, 32'h2);
      rd(cosd_pkg::REG_CTRL, "control", 32'h2);
      wr(cosd_pkg::REG_IMSK, 32'h1);
      put(32'h8);
      put(32'h0);
      chk("request", 32'(seen_req), 32'h1);
      chk("interrupt", 32'(irq), 32'h1);
      rd(cosd_pkg::REG_FIFO, "entry", 32'h8);
      chk("request on pop", 32'(seen_req), 32'h0);
      @(negedge ref_clk);
      chk("request re-armed", 32'(irq_req), 32'h1);
      @(posedge ref_clk);
      rd(cosd_pkg::REG_FIFO, "entry", 32'h0);
      chk("request drained", 32'(seen_req), 32'h0);
      wr(cosd_pkg::REG_CTRL, 32'(cosd_pkg::CTRL_RST));
      wr(cosd_pkg::REG_ISTS, 32'h7);
      chk("interrupt cleared", 32'(irq), 32'h0);
   endtask
   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_start();
      t_modes();
      t_walk();
      t_release();
      stop_test();
   end
   // the sequence needs about 17000 cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end
endmodule
